// ---- hw/bms_device.sv ----
`timescale 1ns/1ps
// How it works
// - Host boot: CPU stalled, rest released
// - Host loads memory while CPU stalled
// - Host sets irq bit to finish boot
// - Irq bit releases CPU to address 0
// - Irq set during stall not latched pending
// - Irq bit releases only in host or emulation boot
// - Host may write and read memory
// - No further irqs until CPU clears bit
// - Emulator sets irq bit in emulation boot
// - Emulator sets breakpoint at address 0
// - ROM boot copies 1K bytes to 0
// - Pack 8/16-bit ROM reads into words
// - Copy is one single-frame block transfer
// - Copy done releases CPU at address 0
// - ROM image stored in system byte order
// - Reset held until clock runs correctly
// - Reset pin low holds internal reset
module bms_device
	import bms_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic reset_n_pin,
	input wire logic [1:0] boot_mode_pin,
	input wire logic [1:0] rom_width_pin,
	bms_link_if.device link,
	output logic rom_rd,
	output logic [31:0] rom_addr,
	input wire logic rom_ack,
	input wire logic [31:0] rom_rdata,
	output logic mem_wr,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	output logic cpu_stall,
	output logic [31:0] cpu_start_addr,
	output logic cpu_irq_pending,
	output logic boot_done,
	output logic internal_rst
);
	typedef enum logic [2:0] {
		BMS_RESET,
		BMS_CAPTURE,
		BMS_HOST_WAIT,
		BMS_COPY,
		BMS_DRAIN,
		BMS_RUN
	} bms_state_t;

	bms_state_t state_reg;
	logic [1:0] rst_sync_reg;
	logic [1:0] mode_sync1_reg;
	logic [1:0] mode_sync2_reg;
	logic [1:0] width_sync1_reg;
	logic [1:0] width_sync2_reg;
	bms_boot_mode_t mode_reg;
	logic [1:0] width_reg;
	logic irq_bit_reg;
	logic irq_rise;
	logic [9:0] rd_byte_reg;
	logic [31:0] pack_reg;
	logic [1:0] lane_reg;
	logic pack_valid;
	logic fifo_ready;
	logic fifo_valid;
	logic [31:0] fifo_data;
	logic [7:0] words_reg;
	logic host_wr_ok;
	logic [31:0] mem_rdata_reg;
	logic mem_ack_reg;

	// Bytes per ROM access for the captured width
	function automatic logic [9:0] step_bytes(input logic [1:0] w);
		case (w)
			BMS_WIDTH_8: step_bytes = 10'h001;
			BMS_WIDTH_16: step_bytes = 10'h002;
			default: step_bytes = 10'h004;
		endcase
	endfunction : step_bytes

	// Internal reset follows the reset pin through a synchroniser
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], reset_n_pin};
		end
	end
	assign internal_rst = ~rst_sync_reg[1];

	always_ff @(posedge clock) begin
		mode_sync1_reg <= boot_mode_pin;
		mode_sync2_reg <= mode_sync1_reg;
		width_sync1_reg <= rom_width_pin;
		width_sync2_reg <= width_sync1_reg;
	end

	// Boot mode and width capture at release
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_reg <= BMS_BOOT_HOST;
			width_reg <= BMS_WIDTH_32;
		end else if (state_reg == BMS_CAPTURE) begin
			mode_reg <= (mode_sync2_reg == 2'h3) ? BMS_BOOT_ROM : bms_boot_mode_t'(mode_sync2_reg);
			width_reg <= (width_sync2_reg == 2'h3) ? BMS_WIDTH_32 : width_sync2_reg;
		end
	end

	// Host-to-CPU irq bit: host set wins over CPU clear
	assign irq_rise = link.irq_set && !irq_bit_reg;
	always_ff @(posedge clock) begin
		if (sys_rst || internal_rst) begin
			irq_bit_reg <= 1'b0;
		end else if (link.irq_set) begin
			irq_bit_reg <= 1'b1;
		end else if (link.cpu_clear) begin
			irq_bit_reg <= 1'b0;
		end
	end
	assign link.irq_bit = irq_bit_reg;

	// Pending irq only when running and bit newly set
	always_ff @(posedge clock) begin
		if (sys_rst || internal_rst) begin
			cpu_irq_pending <= 1'b0;
		end else if (state_reg == BMS_RUN && irq_rise) begin
			cpu_irq_pending <= 1'b1;
		end else if (link.cpu_clear) begin
			cpu_irq_pending <= 1'b0;
		end
	end

	// Boot sequencer
	always_ff @(posedge clock) begin
		if (sys_rst || internal_rst) begin
			state_reg <= BMS_RESET;
		end else begin
			case (state_reg)
				BMS_RESET: state_reg <= BMS_CAPTURE;
				BMS_CAPTURE: state_reg <= (mode_sync2_reg == 2'h2 || mode_sync2_reg == 2'h3) ? BMS_COPY : BMS_HOST_WAIT;
				BMS_HOST_WAIT: begin
					if (irq_bit_reg && mode_reg != BMS_BOOT_ROM) begin
						state_reg <= BMS_RUN;
					end
				end
				BMS_COPY: begin
					if (rom_ack && fifo_ready && rd_byte_reg == BMS_LAST_BYTE + 10'h001 - step_bytes(width_reg)) begin
						state_reg <= BMS_DRAIN;
					end
				end
				BMS_DRAIN: begin
					if (!fifo_valid && !pack_valid) begin
						state_reg <= BMS_RUN;
					end
				end
				BMS_RUN: state_reg <= BMS_RUN;
				default: state_reg <= BMS_RESET;
			endcase
		end
	end

	// ROM read side, stalled by FIFO back-pressure
	assign rom_rd = (state_reg == BMS_COPY) && fifo_ready;
	assign rom_addr = BMS_ROM_BASE + {22'h0, rd_byte_reg};
	always_ff @(posedge clock) begin
		if (sys_rst || internal_rst) begin
			rd_byte_reg <= BMS_ZERO_BYTE;
			lane_reg <= 2'h0;
			pack_reg <= 32'h0000_0000;
		end else if (rom_rd && rom_ack) begin
			rd_byte_reg <= rd_byte_reg + step_bytes(width_reg);
			case (width_reg)
				BMS_WIDTH_8: pack_reg[lane_reg*8 +: 8] <= rom_rdata[7:0];
				BMS_WIDTH_16: pack_reg[lane_reg[0]*16 +: 16] <= rom_rdata[15:0];
				default: pack_reg <= rom_rdata;
			endcase
			lane_reg <= (width_reg == BMS_WIDTH_8) ? lane_reg + 2'h1 :
				(width_reg == BMS_WIDTH_16) ? {1'b0, ~lane_reg[0]} : 2'h0;
		end
	end

	// A packed word is complete after the last lane
	logic word_done_reg;
	always_ff @(posedge clock) begin
		if (sys_rst || internal_rst) begin
			word_done_reg <= 1'b0;
		end else begin
			word_done_reg <= rom_rd && rom_ack && (width_reg == BMS_WIDTH_32 ||
				(width_reg == BMS_WIDTH_16 && lane_reg[0]) || (width_reg == BMS_WIDTH_8 && lane_reg == 2'h3));
		end
	end
	assign pack_valid = word_done_reg;

	bms_fifo #(
		.WIDTH(BMS_DATA_W),
		.DEPTH(BMS_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst || internal_rst),
		.in_valid(pack_valid),
		.in_ready(fifo_ready),
		.in_data(pack_reg),
		.out_valid(fifo_valid),
		.out_ready(!host_wr_ok),
		.out_data(fifo_data)
	);

	// Memory write port: DMA copy words or host accesses
	assign host_wr_ok = (state_reg == BMS_HOST_WAIT) && link.mem_wr;
	always_ff @(posedge clock) begin
		if (sys_rst || internal_rst) begin
			words_reg <= 8'h00;
			mem_wr <= 1'b0;
			mem_addr <= BMS_BOOT_ADDR;
			mem_wdata <= 32'h0000_0000;
		end else if (host_wr_ok) begin
			mem_wr <= 1'b1;
			mem_addr <= link.mem_addr;
			mem_wdata <= link.mem_wdata;
		end else if (fifo_valid) begin
			mem_wr <= 1'b1;
			mem_addr <= BMS_BOOT_ADDR + {22'h0, words_reg, 2'h0};
			mem_wdata <= fifo_data;
			words_reg <= words_reg + 8'h01;
		end else begin
			mem_wr <= 1'b0;
			mem_addr <= link.mem_addr;
		end
	end

	// Host read-back and acknowledge
	always_ff @(posedge clock) begin
		if (sys_rst || internal_rst) begin
			mem_ack_reg <= 1'b0;
			mem_rdata_reg <= 32'h0000_0000;
		end else begin
			mem_ack_reg <= link.mem_allowed && (link.mem_wr || link.mem_rd);
			mem_rdata_reg <= mem_rdata;
		end
	end
	assign link.mem_ack = mem_ack_reg;
	assign link.mem_rdata = mem_rdata_reg;
	assign link.mem_allowed = (state_reg == BMS_HOST_WAIT);

	assign cpu_stall = (state_reg != BMS_RUN);
	assign link.cpu_stalled = cpu_stall;
	assign boot_done = (state_reg == BMS_RUN);
	assign cpu_start_addr = BMS_BOOT_ADDR;
endmodule : bms_device

// ---- hw/bms_fifo.sv ----
`timescale 1ns/1ps
module bms_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_reg];

	always_ff @(posedge clock) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= bump(wr_reg);
			end
			if (pop) begin
				rd_reg <= bump(rd_reg);
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : bms_fifo

// ---- hw/bms_host.sv ----
`timescale 1ns/1ps
module bms_host
	import bms_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	bms_link_if.host link,
	input wire logic emu_mode,
	input wire logic load_req,
	input wire logic load_rd,
	input wire logic [31:0] load_addr,
	input wire logic [31:0] load_data,
	input wire logic load_last,
	output logic load_ready,
	output logic [31:0] read_data,
	output logic read_valid,
	output logic bp_addr_valid,
	output logic [31:0] bp_addr
);
	typedef enum logic [1:0] {
		BMS_H_LOAD,
		BMS_H_WAIT,
		BMS_H_DONE
	} bms_host_state_t;
	bms_host_state_t state_reg;
	logic busy_reg;

	assign load_ready = link.mem_allowed && !busy_reg && state_reg == BMS_H_LOAD;
	assign link.mem_wr = load_ready && load_req && !load_rd;
	assign link.mem_rd = load_ready && load_req && load_rd;
	assign link.mem_addr = load_addr;
	assign link.mem_wdata = load_data;
	// Irq bit set once loading ends, or at once for emulation
	assign link.irq_set = link.mem_allowed && !link.irq_bit &&
		((state_reg == BMS_H_LOAD && emu_mode) || state_reg == BMS_H_WAIT);
	assign link.breakpoint_set = emu_mode && link.cpu_stalled;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= BMS_H_LOAD;
			busy_reg <= 1'b0;
		end else begin
			case (state_reg)
				BMS_H_LOAD: begin
					if (link.mem_wr || link.mem_rd) begin
						busy_reg <= 1'b1;
					end else if (link.mem_ack) begin
						busy_reg <= 1'b0;
					end
					if (emu_mode && link.irq_set) begin
						state_reg <= BMS_H_DONE;
					end else if (load_ready && load_req && load_last) begin
						state_reg <= BMS_H_WAIT;
					end
				end
				BMS_H_WAIT: begin
					if (link.mem_ack) begin
						busy_reg <= 1'b0;
					end
					if (link.irq_set || link.irq_bit) begin
						state_reg <= BMS_H_DONE;
					end
				end
				BMS_H_DONE: state_reg <= BMS_H_DONE;
				default: state_reg <= BMS_H_LOAD;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			read_data <= 32'h0000_0000;
			read_valid <= 1'b0;
			bp_addr_valid <= 1'b0;
			bp_addr <= 32'h0000_0000;
		end else begin
			read_valid <= link.mem_ack;
			if (link.mem_ack) begin
				read_data <= link.mem_rdata;
			end
			if (link.breakpoint_set) begin
				bp_addr_valid <= 1'b1;
				bp_addr <= BMS_BOOT_ADDR;
			end
		end
	end
endmodule : bms_host

// ---- hw/bms_link_if.sv ----
`timescale 1ns/1ps
// Link between the boot sequencer (device end) and host/emulator end
interface bms_link_if;
	import bms_pkg::*;
	logic irq_set;
	logic irq_bit;
	logic cpu_clear;
	logic mem_wr;
	logic mem_rd;
	logic [31:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rdata;
	logic mem_ack;
	logic mem_allowed;
	logic breakpoint_set;
	logic cpu_stalled;
	modport device (
		input irq_set, cpu_clear, mem_wr, mem_rd, mem_addr, mem_wdata, breakpoint_set,
		output irq_bit, mem_rdata, mem_ack, mem_allowed, cpu_stalled
	);
	modport host (
		output irq_set, mem_wr, mem_rd, mem_addr, mem_wdata, breakpoint_set,
		input irq_bit, mem_rdata, mem_ack, mem_allowed, cpu_stalled, cpu_clear
	);
endinterface : bms_link_if

// ---- hw/bms_pkg.sv ----
package bms_pkg;
	// Boot mode encodings
	typedef enum logic [1:0] {
		BMS_BOOT_HOST,
		BMS_BOOT_EMU,
		BMS_BOOT_ROM
	} bms_boot_mode_t;
	// ROM width encodings
	localparam logic [1:0] BMS_WIDTH_8 = 2'h0;
	localparam logic [1:0] BMS_WIDTH_16 = 2'h1;
	localparam logic [1:0] BMS_WIDTH_32 = 2'h2;
	// Boot image size and addresses
	localparam int BMS_IMAGE_BYTES = 1024;
	localparam int BMS_IMAGE_WORDS = BMS_IMAGE_BYTES / 4;
	localparam int BMS_ADDR_W = 32;
	localparam int BMS_DATA_W = 32;
	localparam logic [31:0] BMS_BOOT_ADDR = 32'h0000_0000;
	localparam logic [31:0] BMS_ROM_BASE = 32'h9000_0000;
	localparam int BMS_FIFO_DEPTH = 4;
	localparam logic [9:0] BMS_LAST_BYTE = 10'h3FF;
	localparam logic [9:0] BMS_ZERO_BYTE = 10'h000;
endpackage : bms_pkg

// ---- test/bms_link_sva.sv ----
`timescale 1ns/1ps
module bms_link_sva (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic irq_set,
	input wire logic irq_bit,
	input wire logic cpu_clear,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic mem_ack,
	input wire logic mem_allowed,
	input wire logic cpu_stalled
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_release;
		irq_bit ##1 !cpu_stalled;
	endsequence
	property p_ack;
		(mem_wr || mem_rd) && mem_allowed |=> mem_ack;
	endproperty
	property p_refused;
		!mem_allowed |=> !mem_ack;
	endproperty
	property p_ack_cause;
		mem_ack |-> $past(mem_wr || mem_rd);
	endproperty
	property p_release;
		irq_set && mem_allowed |=> s_release;
	endproperty
	property p_allowed_stalled;
		mem_allowed |-> cpu_stalled;
	endproperty
	property p_hold;
		irq_bit && !cpu_clear |=> irq_bit;
	endproperty
	property p_clear;
		cpu_clear && !irq_set |=> !irq_bit;
	endproperty
	property p_run_stays;
		!cpu_stalled |=> !cpu_stalled;
	endproperty
	a_ack: assert property (p_ack) else $error("request in host wait not acknowledged");
	a_refused: assert property (p_refused) else $error("request outside host wait acknowledged");
	a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
	a_release: assert property (p_release) else $error("irq bit did not release cpu");
	a_allowed_stalled: assert property (p_allowed_stalled) else $error("host access while cpu runs");
	a_hold: assert property (p_hold) else $error("irq bit lost before cpu clear");
	a_clear: assert property (p_clear) else $error("cpu clear ignored");
	a_run_stays: assert property (p_run_stays) else $error("cpu stalled again after release");
endmodule : bms_link_sva

// ---- test/test_boot_mode_sequencer.sv ----
`timescale 1ns/1ps
module test_boot_mode_sequencer;
	import bms_pkg::*;
	logic clock, sys_rst, reset_n_pin, rom_ack, emu_mode, load_req, load_rd, load_last;
	logic [1:0] boot_mode_pin, rom_width_pin;
	logic [31:0] rom_rdata, load_addr, load_data, rom_addr, mem_addr, mem_wdata, cpu_start_addr, read_data, bp_addr;
	logic rom_rd, mem_wr, cpu_stall, cpu_irq_pending, boot_done, internal_rst, load_ready, read_valid, bp_addr_valid;
	logic ooo;
	logic [31:0] rd_seen;
	logic [31:0] mem [256];
	int miscompares, checks, nrd, nwr;
	bms_link_if bms_link_if_i ();
	bms_device bms_device_i (.clock(clock), .sys_rst(sys_rst), .reset_n_pin(reset_n_pin),
		.boot_mode_pin(boot_mode_pin), .rom_width_pin(rom_width_pin), .link(bms_link_if_i.device),
		.rom_rd(rom_rd), .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_rdata(rom_rdata), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem[bms_link_if_i.mem_addr[9:2]]),
		.cpu_stall(cpu_stall), .cpu_start_addr(cpu_start_addr), .cpu_irq_pending(cpu_irq_pending),
		.boot_done(boot_done), .internal_rst(internal_rst));
	bms_host bms_host_i (.clock(clock), .sys_rst(sys_rst), .link(bms_link_if_i.host), .emu_mode(emu_mode),
		.load_req(load_req), .load_rd(load_rd), .load_addr(load_addr), .load_data(load_data),
		.load_last(load_last), .load_ready(load_ready), .read_data(read_data), .read_valid(read_valid),
		.bp_addr_valid(bp_addr_valid), .bp_addr(bp_addr));
	bms_link_sva bms_link_sva_i (.clock(clock), .sys_rst(sys_rst), .irq_set(bms_link_if_i.irq_set),
		.irq_bit(bms_link_if_i.irq_bit), .cpu_clear(bms_link_if_i.cpu_clear), .mem_wr(bms_link_if_i.mem_wr),
		.mem_rd(bms_link_if_i.mem_rd), .mem_ack(bms_link_if_i.mem_ack),
		.mem_allowed(bms_link_if_i.mem_allowed), .cpu_stalled(bms_link_if_i.cpu_stalled));
	function automatic logic [7:0] rb(input logic [31:0] a);
		return a[7:0] ^ a[9:2] ^ 8'hA5;
	endfunction : rb
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Slow ROM, image in system byte order
	always @(negedge clock) begin
		rom_ack <= rom_rd && !rom_ack;
		rom_rdata <= {rb(rom_addr + 3), rb(rom_addr + 2), rb(rom_addr + 1), rb(rom_addr)}
			& (rom_width_pin == BMS_WIDTH_8 ? 32'h0000_00FF : rom_width_pin == BMS_WIDTH_16 ? 32'h0000_FFFF : 32'hFFFF_FFFF);
	end
	always @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < 256; i++) mem[i] <= 32'hFFFF_FFFF;
			nrd <= 0;
			nwr <= 0;
			ooo <= 1'b0;
		end else begin
			if (mem_wr === 1'b1) mem[mem_addr[9:2]] <= mem_wdata;
			if (mem_wr === 1'b1) nwr <= nwr + 1;
			if (mem_wr === 1'b1 && mem_addr !== {nwr[29:0], 2'h0}) ooo <= 1'b1;
			if (rom_rd === 1'b1 && rom_ack === 1'b1) nrd <= nrd + 1;
			if (read_valid === 1'b1) rd_seen <= read_data;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task test_done;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	task boot(input logic [1:0] mode, input logic [1:0] width, input logic emu);
		@(negedge clock);
		sys_rst = 1'b1;
		reset_n_pin = 1'b0;
		boot_mode_pin = mode;
		rom_width_pin = width;
		emu_mode = emu;
		repeat (5) @(negedge clock);
		sys_rst = 1'b0;
		repeat (3) @(negedge clock);
		chk(internal_rst, 1'b1);
		reset_n_pin = 1'b1;
		repeat (8) @(negedge clock);
		boot_mode_pin = ~mode;
	endtask : boot
	task load(input logic rd, input logic [31:0] a, input logic [31:0] d, input logic last);
		int i;
		@(negedge clock);
		load_req = 1'b1;
		load_rd = rd;
		load_addr = a;
		load_data = d;
		load_last = last;
		i = 0;
		while (load_ready !== 1'b1 && i < 20) begin
			@(negedge clock);
			i++;
		end
		@(negedge clock);
		load_req = 1'b0;
		load_last = 1'b0;
		repeat (3) @(negedge clock);
		chk(i < 20, 1'b1);
	endtask : load
	task wait_run;
		int i;
		i = 0;
		while (cpu_stall !== 1'b0 && i < 5000) begin
			@(negedge clock);
			i++;
		end
	endtask : wait_run
	task t_host;
		boot(2'h0, BMS_WIDTH_32, 1'b0);
		chk(cpu_stall, 1'b1);
		load(1'b0, 32'h10, 32'h1234_5678, 1'b0);
		load(1'b0, 32'h14, 32'hCAFE_0001, 1'b0);
		load(1'b1, 32'h10, 32'h0, 1'b0);
		chk(rd_seen, 32'h1234_5678);
		chk(mem[5], 32'hCAFE_0001);
		chk(cpu_stall, 1'b1);
		load(1'b0, 32'h18, 32'h0000_00AA, 1'b1);
		repeat (4) @(negedge clock);
		chk(cpu_stall, 1'b0);
		chk(cpu_start_addr, BMS_BOOT_ADDR);
		chk(cpu_irq_pending, 1'b0);
		chk(bms_link_if_i.irq_bit, 1'b1);
		bms_link_if_i.cpu_clear = 1'b1;
		@(negedge clock);
		bms_link_if_i.cpu_clear = 1'b0;
		@(negedge clock);
		chk(bms_link_if_i.irq_bit, 1'b0);
		chk(nrd, 0);
	endtask : t_host
	task t_emu;
		boot(2'h1, BMS_WIDTH_32, 1'b1);
		wait_run();
		chk(cpu_stall, 1'b0);
		chk({bp_addr_valid, bp_addr[30:0]}, 32'h8000_0000);
		chk(nrd, 0);
	endtask : t_emu
	task t_rom(input logic [1:0] w);
		boot(2'h2, w, 1'b1);
		chk(cpu_stall, 1'b1);
		wait_run();
		chk(boot_done, 1'b1);
		chk(nrd, w == BMS_WIDTH_8 ? 1024 : w == BMS_WIDTH_16 ? 512 : 256);
		chk(nwr, BMS_IMAGE_WORDS);
		chk(ooo, 1'b0);
		chk(rom_rd, 1'b0);
		for (int i = 0; i < BMS_IMAGE_WORDS; i++) begin
			chk(mem[i], {rb(4 * i + 3), rb(4 * i + 2), rb(4 * i + 1), rb(4 * i)});
		end
	endtask : t_rom
	initial begin
		#1000000;
		miscompares++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		reset_n_pin = 1'b0;
		boot_mode_pin = 2'h0;
		rom_width_pin = 2'h0;
		emu_mode = 1'b0;
		load_req = 1'b0;
		load_rd = 1'b0;
		load_addr = 32'h0;
		load_data = 32'h0;
		load_last = 1'b0;
		bms_link_if_i.cpu_clear = 1'b0;
		miscompares = 0;
		checks = 0;
		t_host();
		t_emu();
		for (int w = 0; w < 4; w++) t_rom(w[1:0]);
		test_done();
	end
endmodule : test_boot_mode_sequencer
